// ---- verilog/brer_pkg.sv ----
// Constants shared by the bridge error-reporting block
//
// Contract
// - Drive secondary parity line only as write target or read initiator, enabled.
// - Assert secondary parity line on secondary parity error or upstream delayed-write report.
// - Posted-write parity system error only after a report on the target bus.
// - No system error when the bridge itself detected it as posted-write target.
// - Posted-write parity system error needs both parity response enables set.
// - No system error output unless the global system error enable is set.
// - Every system error assertion also sets the signaled-system-error flag.
// - Forward secondary system error input when forwarding enable is set.
// - Secondary system error input sets the received-system-error flag.
// - Target abort on delivered posted write may raise a system error.
// - Master abort on delivered posted write may raise a system error.
// - Posted write retry limit reached discards data, may raise system error.
// - Delayed write retry limit reached discards data, may raise system error.
// - Delayed read retry limit reached may raise a system error.
// - Delayed transaction master timeout may raise error, own bridge control enable.
// - Master timeout has no per-event disable bit.
// - A status register records which event caused the system error.
// - Per-event disable register bits suppress individual causes.
// - Primary and secondary locks are tracked independently except pass-through.
// - Locks on both buses may be held at once without affecting each other.
package brer_pkg;
   localparam logic [11:0] CTRL_OFF      = 12'h000;
   localparam logic [11:0] DISABLE_OFF   = 12'h004;
   localparam logic [11:0] CAUSE_OFF     = 12'h008;
   localparam logic [11:0] STATUS_OFF    = 12'h00c;
   localparam logic [11:0] RETRY_OFF     = 12'h010;
   localparam logic [11:0] LOCK_OFF      = 12'h014;
   // Control register fields
   localparam int CTL_SERR_EN   = 0;
   localparam int CTL_PPER_EN   = 1;
   localparam int CTL_SPER_EN   = 2;
   localparam int CTL_FWD_EN    = 3;
   localparam int CTL_MTO_EN    = 4;
   // Cause / disable bit positions (master timeout is cause only)
   localparam int EV_PAR   = 0;
   localparam int EV_TABT  = 1;
   localparam int EV_MABT  = 2;
   localparam int EV_PWRT  = 3;
   localparam int EV_DWRT  = 4;
   localparam int EV_DRRT  = 5;
   localparam int EV_MTO   = 6;
   localparam int EV_FWD   = 7;
   localparam int NUM_EV   = 8;
   // Status register fields
   localparam int ST_SIG    = 0;
   localparam int ST_RCV    = 1;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [31:0] DISABLE_RST = 32'h0000_0000;
   localparam int RETRY_LIMIT_LOG2 = 24;
   localparam logic [31:0] RETRY_RST   = 32'h0100_0000;
endpackage : brer_pkg

// ---- verilog/brer_retry_cnt.sv ----
// Per-queue target retry counter that flags when the limit is reached
`timescale 1ns/1ps
module brer_retry_cnt
   import brer_pkg::*;
#(
   parameter int WIDTH = 25
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Events
   input  wire logic             retry,
   input  wire logic             done,
   input  wire logic [WIDTH-1:0] limit,
   // Result
   output logic                  expired
);
   if (WIDTH < 2) begin : g_bad_width
      $error("brer_retry_cnt WIDTH too small");
   end

   logic [WIDTH-1:0] cnt_ff;
   wire  [WIDTH-1:0] nxt_cnt = cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
   wire              hit     = retry && (nxt_cnt >= limit);

   // One-cycle pulse; the transfer is dropped, so the count restarts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff  <= '0;
         expired <= 1'b0;
      end else begin
         expired <= hit;
         if (done || hit)
            cnt_ff <= '0;
         else if (retry)
            cnt_ff <= nxt_cnt;
      end
   end
endmodule : brer_retry_cnt

// ---- verilog/brer_top.sv ----
// Bridge system-error and parity-error reporting with APB registers
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module brer_top
   import brer_pkg::*;
#(
   parameter int RETRY_W = 25
) (
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Secondary parity context
   input  wire logic        sec_write_target,
   input  wire logic        sec_read_initiator,
   input  wire logic        sec_parity_detected,
   input  wire logic        up_dwr_completion,
   input  wire logic        primary_parity_error_line,
   input  wire logic        secondary_parity_error_line_in,
   // Posted-write parity reports
   input  wire logic        up_posted_active,
   input  wire logic        dn_posted_active,
   input  wire logic        posted_par_self_detected,
   // Delivery events
   input  wire logic        pw_target_abort,
   input  wire logic        pw_master_abort,
   input  wire logic        pw_retry,
   input  wire logic        pw_done,
   input  wire logic        dw_retry,
   input  wire logic        dw_done,
   input  wire logic        dr_retry,
   input  wire logic        dr_done,
   input  wire logic        dt_master_timeout,
   input  wire logic        secondary_system_error_in,
   // Lock observation
   input  wire logic        pri_lock_set,
   input  wire logic        pri_lock_clr,
   input  wire logic        sec_lock_set,
   input  wire logic        sec_lock_clr,
   input  wire logic        lock_pass_through,
   // Outputs
   output logic             primary_system_error_out,
   output logic             secondary_parity_error_line,
   output logic             secondary_parity_error_oe,
   output logic             pw_discard,
   output logic             dw_discard,
   output logic             pri_locked,
   output logic             sec_locked
);
   // Counter must reach the default limit and fit the 32-bit read word
   if (RETRY_W <= RETRY_LIMIT_LOG2 || RETRY_W > 31) begin : g_bad_retry_w
      $error("RETRY_W out of range");
   end

   logic [31:0]       ctrl_ff;
   logic [NUM_EV-1:0] dis_ff;
   logic [NUM_EV-1:0] cause_ff;
   logic [1:0]        stat_ff;
   logic [RETRY_W-1:0] limit_ff;
   logic              serr_ff;
   logic              sperr_ff;
   logic              sperr_oe_ff;
   logic              plock_ff;
   logic              slock_ff;
   logic [31:0]       prdata_ff;

   // APB decode
   wire acc      = psel && penable;
   wire wr       = acc && pwrite;
   wire hit_ctrl = paddr == CTRL_OFF;
   wire hit_dis  = paddr == DISABLE_OFF;
   wire hit_cse  = paddr == CAUSE_OFF;
   wire hit_st   = paddr == STATUS_OFF;
   wire hit_rt   = paddr == RETRY_OFF;
   wire hit_lk   = paddr == LOCK_OFF;
   wire mapped   = hit_ctrl | hit_dis | hit_cse | hit_st | hit_rt | hit_lk;
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   wire serr_en = ctrl_ff[CTL_SERR_EN];
   wire pper_en = ctrl_ff[CTL_PPER_EN];
   wire sper_en = ctrl_ff[CTL_SPER_EN];

   // Retry limit counters
   logic pw_exp;
   logic dw_exp;
   logic dr_exp;
   brer_retry_cnt #(.WIDTH(RETRY_W)) u_pw (
      .pclk(pclk), .presetn(presetn), .retry(pw_retry), .done(pw_done),
      .limit(limit_ff), .expired(pw_exp));
   brer_retry_cnt #(.WIDTH(RETRY_W)) u_dw (
      .pclk(pclk), .presetn(presetn), .retry(dw_retry), .done(dw_done),
      .limit(limit_ff), .expired(dw_exp));
   brer_retry_cnt #(.WIDTH(RETRY_W)) u_dr (
      .pclk(pclk), .presetn(presetn), .retry(dr_retry), .done(dr_done),
      .limit(limit_ff), .expired(dr_exp));

   // Parity report seen on the target bus of a posted write
   wire pri_perr_seen = !primary_parity_error_line;
   wire sec_perr_seen = !secondary_parity_error_line_in;
   wire par_ev = ((up_posted_active && pri_perr_seen)
                 || (dn_posted_active && sec_perr_seen))
                 && !posted_par_self_detected
                 && pper_en && sper_en;

   // Raw events; master timeout uses its own enable only
   wire [NUM_EV-1:0] ev_raw;
   assign ev_raw[EV_PAR]  = par_ev;
   assign ev_raw[EV_TABT] = pw_target_abort;
   assign ev_raw[EV_MABT] = pw_master_abort;
   assign ev_raw[EV_PWRT] = pw_exp;
   assign ev_raw[EV_DWRT] = dw_exp;
   assign ev_raw[EV_DRRT] = dr_exp;
   assign ev_raw[EV_MTO]  = dt_master_timeout
                            && ctrl_ff[CTL_MTO_EN];
   assign ev_raw[EV_FWD]  = !secondary_system_error_in
                            && ctrl_ff[CTL_FWD_EN];

   // Disable bit for master timeout is forced off
   wire [NUM_EV-1:0] dis_eff = dis_ff
                             & ~(NUM_EV'(1) << EV_MTO);
   wire [NUM_EV-1:0] ev_gated = ev_raw & ~dis_eff;
   wire              fire     = serr_en && (|ev_gated);

   // Secondary parity line
   wire sper_cond = sper_en
                  && (sec_write_target || sec_read_initiator);
   wire sper_ev   = sec_parity_detected
                  || (up_dwr_completion && pri_perr_seen);
   assign pw_discard = pw_exp;
   assign dw_discard = dw_exp;

   // Register write data
   wire cause_clr_wr = wr && hit_cse;
   wire stat_clr_wr  = wr && hit_st;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff  <= CTRL_RST;
         dis_ff   <= DISABLE_RST[NUM_EV-1:0];
         limit_ff <= RETRY_RST[RETRY_W-1:0];
      end else if (wr) begin
         if (hit_ctrl)
            ctrl_ff <= pwdata;
         if (hit_dis)
            dis_ff <= pwdata[NUM_EV-1:0];
         if (hit_rt)
            limit_ff <= pwdata[RETRY_W-1:0];
      end
   end

   // Sticky cause and status; set wins over write-one-to-clear
   wire [NUM_EV-1:0] cause_clr = cause_clr_wr ? pwdata[NUM_EV-1:0] : '0;
   wire [1:0]        stat_clr  = stat_clr_wr ? pwdata[1:0] : 2'b00;
   wire [NUM_EV-1:0] nxt_cause = (cause_ff & ~cause_clr)
                               | (fire ? ev_gated : '0);
   wire [1:0]        stat_set;
   assign stat_set[ST_SIG] = fire;
   assign stat_set[ST_RCV] = !secondary_system_error_in;
   wire [1:0]        nxt_stat  = (stat_ff & ~stat_clr) | stat_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_ff <= '0;
         stat_ff  <= '0;
      end else begin
         cause_ff <= nxt_cause;
         stat_ff  <= nxt_stat;
      end
   end

   // Output lines, active low; parity-line enable active high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serr_ff     <= 1'b0;
         sperr_ff    <= 1'b0;
         sperr_oe_ff <= 1'b0;
      end else begin
         serr_ff     <= fire;
         sperr_ff    <= sper_cond && sper_ev;
         sperr_oe_ff <= sper_cond;
      end
   end
   assign primary_system_error_out    = !serr_ff;
   assign secondary_parity_error_line = !sperr_ff;
   assign secondary_parity_error_oe   = sperr_oe_ff;

   // Independent lock tracking; a pass-through lock holds both
   wire nxt_plock = pri_lock_set || (plock_ff && !pri_lock_clr);
   wire nxt_slock = sec_lock_set || (lock_pass_through && pri_lock_set)
                  || (slock_ff && !sec_lock_clr);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         plock_ff <= 1'b0;
         slock_ff <= 1'b0;
      end else begin
         plock_ff <= nxt_plock;
         slock_ff <= nxt_slock;
      end
   end
   assign pri_locked = plock_ff;
   assign sec_locked = slock_ff;

   // Read mux
   wire [31:0] rd_mux =
        hit_ctrl ? ctrl_ff
      : hit_dis  ? {{(32-NUM_EV){1'b0}}, dis_ff}
      : hit_cse  ? {{(32-NUM_EV){1'b0}}, cause_ff}
      : hit_st   ? {30'h0, stat_ff}
      : hit_rt   ? {{(32-RETRY_W){1'b0}}, limit_ff}
      : hit_lk   ? {30'h0, slock_ff, plock_ff}
      : 32'h0;
   // Captured in the setup cycle so the access phase sees a stable word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_ff <= 32'h0;
      else if (psel && !penable)
         prdata_ff <= rd_mux;
   end
   assign prdata = prdata_ff;

   // Checks
   property p_no_serr_without_en;
      @(posedge pclk) disable iff (!presetn)
      !serr_en |=> primary_system_error_out;
   endproperty
   a_no_serr_without_en: assert property (p_no_serr_without_en)
      else $error("system error without enable");

   property p_sig_flag;
      @(posedge pclk) disable iff (!presetn)
      !primary_system_error_out |-> stat_ff[ST_SIG];
   endproperty
   a_sig_flag: assert property (p_sig_flag)
      else $error("signaled flag missing");

   property p_fwd;
      @(posedge pclk) disable iff (!presetn)
      (!secondary_system_error_in && ctrl_ff[CTL_FWD_EN] && serr_en
       && !dis_ff[EV_FWD]) |=> !primary_system_error_out;
   endproperty
   a_fwd: assert property (p_fwd)
      else $error("secondary system error not forwarded");

   property p_rcv;
      @(posedge pclk) disable iff (!presetn)
      !secondary_system_error_in |=> stat_ff[ST_RCV];
   endproperty
   a_rcv: assert property (p_rcv)
      else $error("received flag missing");

   property p_self;
      @(posedge pclk) disable iff (!presetn)
      (posted_par_self_detected && !cause_ff[EV_PAR])
         |=> !cause_ff[EV_PAR];
   endproperty
   a_self: assert property (p_self)
      else $error("self-detected parity reported");

   property p_mto;
      @(posedge pclk) disable iff (!presetn)
      (dt_master_timeout && ctrl_ff[CTL_MTO_EN] && serr_en)
         |=> cause_ff[EV_MTO] && !primary_system_error_out;
   endproperty
   a_mto: assert property (p_mto)
      else $error("master timeout not reported");

   property p_sper_drive;
      @(posedge pclk) disable iff (!presetn)
      !secondary_parity_error_line |-> secondary_parity_error_oe;
   endproperty
   a_sper_drive: assert property (p_sper_drive)
      else $error("parity line driven out of role");

   property p_disable;
      @(posedge pclk) disable iff (!presetn)
      (dis_ff[EV_TABT] && !cause_ff[EV_TABT] && !cause_clr_wr)
         |=> !cause_ff[EV_TABT];
   endproperty
   a_disable: assert property (p_disable)
      else $error("disabled cause recorded");

   // Multi-step checks; the parity-report, abort and retry-limit ones use named sequences
   sequence s_pw_par_report;
      (up_posted_active && !primary_parity_error_line)
      || (dn_posted_active && !secondary_parity_error_line_in);
   endsequence

   sequence s_serr_asserted;
      !primary_system_error_out && stat_ff[ST_SIG];
   endsequence

   property p_par_report;
      @(posedge pclk) disable iff (!presetn)
      s_pw_par_report ##0 (!posted_par_self_detected && pper_en && sper_en
                           && serr_en && !dis_ff[EV_PAR])
         |=> s_serr_asserted ##0 cause_ff[EV_PAR];
   endproperty
   a_par_report: assert property (p_par_report)
      else $error("posted-write parity report not raised");

   property p_par_en;
      @(posedge pclk) disable iff (!presetn)
      (!(pper_en && sper_en) && !cause_ff[EV_PAR]) |=> !cause_ff[EV_PAR];
   endproperty
   a_par_en: assert property (p_par_en)
      else $error("parity cause recorded without both enables");

   property p_tabt;
      @(posedge pclk) disable iff (!presetn)
      (pw_target_abort && serr_en && !dis_ff[EV_TABT])
         |=> s_serr_asserted ##0 cause_ff[EV_TABT];
   endproperty
   a_tabt: assert property (p_tabt)
      else $error("target abort not reported");

   property p_mabt;
      @(posedge pclk) disable iff (!presetn)
      (pw_master_abort && serr_en && !dis_ff[EV_MABT])
         |=> s_serr_asserted ##0 cause_ff[EV_MABT];
   endproperty
   a_mabt: assert property (p_mabt)
      else $error("master abort not reported");

   property p_pw_limit;
      @(posedge pclk) disable iff (!presetn)
      (pw_exp && serr_en && !dis_ff[EV_PWRT])
         |-> pw_discard ##1 (s_serr_asserted ##0 cause_ff[EV_PWRT]);
   endproperty
   a_pw_limit: assert property (p_pw_limit)
      else $error("posted retry limit not reported");

   property p_mto_gate;
      @(posedge pclk) disable iff (!presetn)
      (dt_master_timeout && !ctrl_ff[CTL_MTO_EN] && !cause_ff[EV_MTO])
         |=> !cause_ff[EV_MTO];
   endproperty
   a_mto_gate: assert property (p_mto_gate)
      else $error("master timeout recorded while disabled");

   property p_sper_assert;
      @(posedge pclk) disable iff (!presetn)
      (sper_cond && sper_ev)
         |=> !secondary_parity_error_line && secondary_parity_error_oe;
   endproperty
   a_sper_assert: assert property (p_sper_assert)
      else $error("secondary parity line not asserted");

   property p_lock_pass;
      @(posedge pclk) disable iff (!presetn)
      (pri_lock_set && lock_pass_through) |=> pri_locked && sec_locked;
   endproperty
   a_lock_pass: assert property (p_lock_pass)
      else $error("pass-through lock not held on both buses");
endmodule : brer_top

// ---- verification/brer_bus_model.sv ----
// Far-side bus model driving the active-low error lines into the bridge
`timescale 1ns/1ps
module brer_bus_model (
   // Clock
   input  wire logic pclk,
   // Bench requests, high to assert a line
   input  wire logic [2:0] req,
   // Active-low lines, pulled up when released
   output logic      secondary_system_error_in,
   output logic      primary_parity_error_line,
   output logic      secondary_parity_error_line_in
);
   initial begin
      secondary_system_error_in      = 1'b1;
      primary_parity_error_line      = 1'b1;
      secondary_parity_error_line_in = 1'b1;
   end
   // Released lines float to the pull-up level
   always @(posedge pclk) begin
      secondary_system_error_in      <= ~req[0];
      primary_parity_error_line      <= ~req[1];
      secondary_parity_error_line_in <= ~req[2];
   end
endmodule : brer_bus_model

// ---- verification/tb_brer_top.sv ----
// Self-checking bench for the bridge error-reporting block
`timescale 1ns/1ps
module tb_brer_top
   import brer_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        serr_o, sper_o, sper_oe, pw_disc, dw_disc, pri_lk, sec_lk;
   logic        s_serr, p_perr, s_perr, lpt;
   logic [12:0] ev;
   logic [6:0]  lv;
   logic [2:0]  req;
   logic [3:0]  seen;
   logic        seen_clr;
   int          mismatches, n_checks;

   // ev: 0 tabt 1 mabt 2-4 pw/dw/dr retry 5 mto 6-8 done 9-12 lock events
   // lv: 0 wr tgt 1 rd init 2 sec par 3 up dwr 4 up pw 5 dn pw 6 self
   brer_top brer_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .sec_write_target(lv[0]), .sec_read_initiator(lv[1]),
      .sec_parity_detected(lv[2]), .up_dwr_completion(lv[3]),
      .primary_parity_error_line(p_perr),
      .secondary_parity_error_line_in(s_perr),
      .up_posted_active(lv[4]), .dn_posted_active(lv[5]),
      .posted_par_self_detected(lv[6]),
      .pw_target_abort(ev[0]), .pw_master_abort(ev[1]), .pw_retry(ev[2]),
      .dw_retry(ev[3]), .dr_retry(ev[4]), .dt_master_timeout(ev[5]),
      .pw_done(ev[6]), .dw_done(ev[7]), .dr_done(ev[8]),
      .secondary_system_error_in(s_serr),
      .pri_lock_set(ev[9]), .pri_lock_clr(ev[10]), .sec_lock_set(ev[11]),
      .sec_lock_clr(ev[12]), .lock_pass_through(lpt),
      .primary_system_error_out(serr_o), .secondary_parity_error_line(sper_o),
      .secondary_parity_error_oe(sper_oe), .pw_discard(pw_disc),
      .dw_discard(dw_disc), .pri_locked(pri_lk), .sec_locked(sec_lk));

   brer_bus_model brer_bus_model_i (.pclk(pclk), .req(req),
      .secondary_system_error_in(s_serr), .primary_parity_error_line(p_perr),
      .secondary_parity_error_line_in(s_perr));

   always #4 pclk = ~pclk;

   // Sticky record of short pulses so none is missed between checks
   always @(posedge pclk) begin
      if (!presetn || seen_clr) begin
         seen <= 4'h0;
      end else begin
         if (serr_o === 1'b0) seen[0] <= 1'b1;
         if (pw_disc === 1'b1) seen[1] <= 1'b1;
         if (dw_disc === 1'b1) seen[2] <= 1'b1;
         if (sper_oe === 1'b1 && sper_o === 1'b0) seen[3] <= 1'b1;
      end
   end

   function automatic logic [31:0] bt(input int i);
      return 32'h1 << i;
   endfunction : bt

   task report_and_stop;
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         mismatches++;
         report_and_stop();
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so a following request never re-drives psel in this step
      @(posedge pclk);
   endtask : apb

   task rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdchk

   task pulse(input int i);
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev[i] <= 1'b0;
      @(posedge pclk);
   endtask : pulse

   // Wipe recorded causes and flags before the next scenario
   task clr(input logic [31:0] ctl);
      apb(1'b1, CAUSE_OFF, 32'hff);
      apb(1'b1, STATUS_OFF, 32'h3);
      apb(1'b1, CTRL_OFF, ctl);
      repeat (3) @(posedge pclk);
      seen_clr <= 1'b1;
      @(posedge pclk);
      seen_clr <= 1'b0;
   endtask : clr

   task settle(input string name);
      repeat (4) @(posedge pclk);
      $display("Test %s done", name);
   endtask : settle

   task t_reset;
      chk({31'h0, serr_o}, 32'h1);
      chk({31'h0, sper_oe}, 32'h0);
      rdchk(CTRL_OFF, CTRL_RST);
      rdchk(RETRY_OFF, RETRY_RST);
      rdchk(12'h020, 32'h0);
      chk({31'h0, slv}, 32'h1);
      settle("reset");
   endtask : t_reset

   task t_fwd;
      clr(bt(CTL_FWD_EN));
      req[0] <= 1'b1;
      repeat (3) @(posedge pclk);
      req[0] <= 1'b0;
      settle("fwd gated");
      chk(32'(seen), 32'h0);
      rdchk(STATUS_OFF, bt(ST_RCV));
      clr(bt(CTL_FWD_EN) | bt(CTL_SERR_EN));
      req[0] <= 1'b1;
      repeat (3) @(posedge pclk);
      req[0] <= 1'b0;
      settle("fwd");
      chk(32'(seen), 32'h1);
      rdchk(STATUS_OFF, 32'h3);
      rdchk(CAUSE_OFF, bt(EV_FWD));
   endtask : t_fwd

   task t_par(input logic [31:0] ctl, input logic [6:0] l,
              input logic [2:0] r, input logic [3:0] e);
      clr(ctl);
      lv <= l;
      req <= r;
      repeat (3) @(posedge pclk);
      lv <= 7'h0;
      req <= 3'h0;
      settle("parity");
      chk(32'(seen), 32'(e));
   endtask : t_par

   task t_ev(input logic [31:0] dis, input int i, input logic [31:0] cause,
             input logic [3:0] e);
      clr(bt(CTL_SERR_EN) | bt(CTL_MTO_EN));
      apb(1'b1, DISABLE_OFF, dis);
      pulse(i);
      settle("event");
      chk(32'(seen), 32'(e));
      rdchk(CAUSE_OFF, cause);
   endtask : t_ev

   task t_retry(input int r, input int d, input int cb, input int sb);
      clr(bt(CTL_SERR_EN));
      apb(1'b1, DISABLE_OFF, 32'h0);
      apb(1'b1, RETRY_OFF, 32'h4);
      repeat (3) pulse(r);
      pulse(d);
      repeat (3) pulse(r);
      chk(32'(seen), 32'h0);
      pulse(r);
      settle("retry");
      chk(32'(seen), 32'(1 | sb));
      rdchk(CAUSE_OFF, bt(cb));
   endtask : t_retry

   task t_lock;
      pulse(9);
      chk({30'h0, pri_lk, sec_lk}, 32'h2);
      pulse(11);
      pulse(10);
      chk({30'h0, pri_lk, sec_lk}, 32'h1);
      pulse(12);
      lpt <= 1'b1;
      pulse(9);
      lpt <= 1'b0;
      chk({30'h0, pri_lk, sec_lk}, 32'h3);
      settle("lock");
   endtask : t_lock

   task t_mto_off;
      clr(bt(CTL_SERR_EN));
      pulse(5);
      settle("mto gated");
      chk(32'(seen), 32'h0);
   endtask : t_mto_off

   // Reset in mid-run must drop locks and restore the retry limit
   task t_rst2;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({30'h0, pri_lk, sec_lk}, 32'h0);
      rdchk(RETRY_OFF, RETRY_RST);
      settle("mid reset");
   endtask : t_rst2

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, lpt} = 4'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      ev = 13'h0;
      lv = 7'h0;
      req = 3'h0;
      seen_clr = 1'b0;
      mismatches = 0;
      n_checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_fwd();
      // Parity: one enable off, self-detected, primary and secondary reports
      t_par(bt(CTL_SERR_EN) | bt(CTL_SPER_EN), 7'h10, 3'h2, 4'h0);
      t_par(32'h7, 7'h50, 3'h2, 4'h0);
      t_par(32'h7, 7'h10, 3'h2, 4'h1);
      t_par(32'h7, 7'h20, 3'h4, 4'h1);
      t_par(32'h7, 7'h20, 3'h0, 4'h0);
      t_par(bt(CTL_SPER_EN), 7'h04, 3'h0, 4'h0);
      t_par(bt(CTL_SPER_EN), 7'h05, 3'h0, 4'h8);
      t_par(bt(CTL_SPER_EN), 7'h09, 3'h2, 4'h8);
      t_ev(bt(EV_TABT), 0, 32'h0, 4'h0);
      t_ev(bt(EV_TABT), 1, bt(EV_MABT), 4'h1);
      t_ev(32'h0, 0, bt(EV_TABT), 4'h1);
      t_ev(32'hff, 5, bt(EV_MTO), 4'h1);
      t_mto_off();
      t_retry(2, 6, EV_PWRT, 2);
      t_retry(3, 7, EV_DWRT, 4);
      t_retry(4, 8, EV_DRRT, 0);
      t_lock();
      t_rst2();
      report_and_stop();
   end
endmodule : tb_brer_top
